// [jbsp_tap.v]
// Behaviour
// - instruction register is ten bits, shifted in serially.
// - bypass puts one flip-flop between data in and data out.
// - sample/preload captures pins and loads a pattern for later drive.
// - extest drives scan pattern on outputs, captures inputs.
// - usercode connects user signature register and shifts it out.
// - user signature is 32 bits: 7 from configuration, 25 fixed.
// - idcode connects identification register and shifts it out.
// - scan chain length 690, 1308 or 1446 cells by density.
// - vendor configuration instructions load configuration serially over the port.
// - id lowest bit is one and leaves first.
`timescale 1ns/1ps
`default_nettype none
`include "jbsp_defs.vh"
module jbsp_tap #(
  parameter BSR_LEN = `JBSP_BSR_SMALL
) (
  input  wire               i_mclk,     // system clock 50 MHz
  input  wire               i_sys_rst,  // sync reset, active high
  input  wire               i_tck,      // test clock pin
  input  wire               i_tms,      // test mode select pin
  input  wire               i_tdi,      // test data in pin
  input  wire               i_trst_n,   // optional test reset, active low
  output reg                o_tdo,      // test data out pin
  output reg                o_tdo_oe_n, // tdo enable, low drives
  input  wire [BSR_LEN-1:0] i_pins,     // pin values seen by scan cells
  output reg  [BSR_LEN-1:0] o_pins,     // pattern for pins in extest
  output reg                o_pin_test, // high while extest controls pins
  input  wire [6:0]         i_user_sig, // configured user signature bits
  input  wire               i_cfg_busy, // configuration in progress
  output reg  [7:0]         o_cfg_data, // configuration byte
  output reg                o_cfg_valid,// configuration byte valid
  input  wire               i_cfg_ready,// configuration sink ready
  output reg                o_cfg_start,// pulse: start configured device
  output reg                o_cfg_ovf   // byte lost to full buffer
);
  // input synchronisers
  reg [1:0] tck_s;
  reg [1:0] tms_s;
  reg [1:0] tdi_s;
  reg [1:0] trst_s;
  reg       tck_d;
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      tck_s  <= 2'h0;
      tms_s  <= 2'h3;
      tdi_s  <= 2'h3;
      trst_s <= 2'h3;
      tck_d  <= 1'b0;
    end else begin
      tck_s  <= {tck_s[0], i_tck};
      tms_s  <= {tms_s[0], i_tms};
      tdi_s  <= {tdi_s[0], i_tdi};
      trst_s <= {trst_s[0], i_trst_n};
      tck_d  <= tck_s[1];
    end
  end
  wire tck_rise = tck_s[1] & ~tck_d;
  wire tck_fall = ~tck_s[1] & tck_d;
  wire tms = tms_s[1];
  wire tdi = tdi_s[1];
  wire trst_n = trst_s[1];

  // pin values cross into the system clock before the scan cells capture them
  reg [BSR_LEN-1:0] pins_s1;
  reg [BSR_LEN-1:0] pins_s2;
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pins_s1 <= {BSR_LEN{1'b0}};
      pins_s2 <= {BSR_LEN{1'b0}};
    end else begin
      pins_s1 <= i_pins;
      pins_s2 <= pins_s1;
    end
  end

  reg [3:0] state;
  reg [3:0] next_state;
  always @* begin
    next_state = state;
    case (state)
      `JBSP_TLR: next_state = tms ? `JBSP_TLR : `JBSP_RTI;
      `JBSP_RTI: next_state = tms ? `JBSP_SDS : `JBSP_RTI;
      `JBSP_SDS: next_state = tms ? `JBSP_SIS : `JBSP_CDR;
      `JBSP_CDR: next_state = tms ? `JBSP_E1D : `JBSP_SDR;
      `JBSP_SDR: next_state = tms ? `JBSP_E1D : `JBSP_SDR;
      `JBSP_E1D: next_state = tms ? `JBSP_UDR : `JBSP_PDR;
      `JBSP_PDR: next_state = tms ? `JBSP_E2D : `JBSP_PDR;
      `JBSP_E2D: next_state = tms ? `JBSP_UDR : `JBSP_SDR;
      `JBSP_UDR: next_state = tms ? `JBSP_SDS : `JBSP_RTI;
      `JBSP_SIS: next_state = tms ? `JBSP_TLR : `JBSP_CIR;
      `JBSP_CIR: next_state = tms ? `JBSP_E1I : `JBSP_SIR;
      `JBSP_SIR: next_state = tms ? `JBSP_E1I : `JBSP_SIR;
      `JBSP_E1I: next_state = tms ? `JBSP_UIR : `JBSP_PIR;
      `JBSP_PIR: next_state = tms ? `JBSP_E2I : `JBSP_PIR;
      `JBSP_E2I: next_state = tms ? `JBSP_UIR : `JBSP_SIR;
      `JBSP_UIR: next_state = tms ? `JBSP_SDS : `JBSP_RTI;
      default:   next_state = `JBSP_TLR;
    endcase
  end

  // instruction decode
  reg [`JBSP_IR_LEN-1:0] ir_shift;
  reg [`JBSP_IR_LEN-1:0] ir;
  wire op_extest = (ir == `JBSP_OP_EXTEST);
  wire op_sample = (ir == `JBSP_OP_SAMPLE);
  wire op_idcode = (ir == `JBSP_OP_IDCODE);
  wire op_user   = (ir == `JBSP_OP_USERCODE);
  wire op_prog   = (ir == `JBSP_OP_CFG_PROG);
  wire op_start  = (ir == `JBSP_OP_CFG_START);
  wire op_bsr    = op_extest | op_sample;
  wire op_bypass = ~(op_bsr | op_idcode | op_user | op_prog | op_start);

  wire [31:0] id_word = {`JBSP_ID_VERSION, `JBSP_ID_PART, `JBSP_ID_MAKER, 1'b1};
  wire [31:0] uc_word = {`JBSP_UC_FIXED, i_user_sig};

  reg               bypass_reg;
  reg [31:0]        dr32;
  reg [BSR_LEN-1:0] bsr;
  reg [7:0]         cfg_sh;
  reg [2:0]         cfg_cnt;
  reg               cfg_push;
  reg [7:0]         cfg_byte;
  reg               tdo_next;

  always @* begin
    tdo_next = bypass_reg;
    if (state == `JBSP_SIR)
      tdo_next = ir_shift[0];
    else if (op_bsr)
      tdo_next = bsr[0];
    else if (op_idcode | op_user)
      tdo_next = dr32[0];
    else if (op_prog)
      tdo_next = cfg_sh[0];
  end

  wire fifo_ready;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire pop = fifo_valid && (!o_cfg_valid || i_cfg_ready);

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state      <= `JBSP_TLR;
      ir_shift   <= {`JBSP_IR_LEN{1'b0}};
      ir         <= `JBSP_OP_IDCODE;
      bypass_reg <= 1'b0;
      dr32       <= 32'h0;
      bsr        <= {BSR_LEN{1'b0}};
      o_pins     <= {BSR_LEN{1'b0}};
      o_pin_test <= 1'b0;
      cfg_sh     <= 8'h0;
      cfg_cnt    <= 3'h0;
      cfg_push   <= 1'b0;
      cfg_byte   <= 8'h0;
      o_cfg_start <= 1'b0;
      o_cfg_ovf  <= 1'b0;
      o_tdo      <= 1'b1;
      o_tdo_oe_n <= 1'b1;
    end else begin
      cfg_push    <= 1'b0;
      o_cfg_start <= 1'b0;
      o_cfg_ovf   <= 1'b0;
      if (!trst_n) begin
        state      <= `JBSP_TLR;
        ir         <= `JBSP_OP_IDCODE;
        o_pin_test <= 1'b0;
      end else if (tck_rise) begin
        state <= next_state;
        case (state)
          `JBSP_TLR: begin
            ir         <= `JBSP_OP_IDCODE;
            o_pin_test <= 1'b0;
          end
          `JBSP_CIR: ir_shift <= `JBSP_IR_CAPTURE;
          `JBSP_SIR: ir_shift <= {tdi, ir_shift[`JBSP_IR_LEN-1:1]};
          `JBSP_UIR: begin
            ir         <= ir_shift;
            o_pin_test <= (ir_shift == `JBSP_OP_EXTEST);
          end
          `JBSP_CDR: begin
            bypass_reg <= 1'b0;
            if (op_idcode)
              dr32 <= id_word;
            if (op_user)
              dr32 <= uc_word;
            if (op_bsr)
              bsr <= pins_s2;
            cfg_cnt <= 3'h0;
          end
          `JBSP_SDR: begin
            bypass_reg <= tdi;
            dr32 <= {tdi, dr32[31:1]};
            if (op_bsr)
              bsr <= {tdi, bsr[BSR_LEN-1:1]};
            if (op_prog) begin
              cfg_sh  <= {tdi, cfg_sh[7:1]};
              cfg_cnt <= cfg_cnt + 3'h1;
              if (cfg_cnt == 3'h7) begin
                cfg_push <= 1'b1;
                cfg_byte <= {tdi, cfg_sh[7:1]};
              end
            end
          end
          `JBSP_UDR: begin
            if (op_bsr)
              o_pins <= bsr;
            if (op_start)
              o_cfg_start <= 1'b1;
          end
          default: begin
          end
        endcase
      end
      if (cfg_push && !fifo_ready)
        o_cfg_ovf <= 1'b1;
      if (tck_fall) begin
        o_tdo      <= tdo_next;
        o_tdo_oe_n <= ~((state == `JBSP_SIR) | (state == `JBSP_SDR));
      end
      if (state == `JBSP_TLR)
        o_tdo_oe_n <= 1'b1;
    end
  end

  jbsp_fifo #(
    .WIDTH (`JBSP_CFG_W),
    .DEPTH (`JBSP_CFG_DEPTH),
    .AW    (`JBSP_CFG_AW)
  ) u_fifo (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_data    (cfg_byte),
    .i_valid   (cfg_push),
    .o_ready   (fifo_ready),
    .o_data    (fifo_data),
    .o_valid   (fifo_valid),
    .i_ready   (pop)
  );

  // output stage register for configuration stream
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_cfg_valid <= 1'b0;
      o_cfg_data  <= 8'h0;
    end else if (pop) begin
      o_cfg_valid <= 1'b1;
      o_cfg_data  <= fifo_data;
    end else if (i_cfg_ready) begin
      o_cfg_valid <= 1'b0;
    end
  end
  // i_cfg_busy is advisory: boundary testing during configuration is the controller's duty
  wire unused_busy = i_cfg_busy;
endmodule
`default_nettype wire

// [jbsp_defs.vh]
`ifndef JBSP_DEFS_VH
`define JBSP_DEFS_VH
// instruction register
`define JBSP_IR_LEN       10
`define JBSP_IR_CAPTURE   10'h001
`define JBSP_OP_EXTEST    10'h000
`define JBSP_OP_SAMPLE    10'h005
`define JBSP_OP_IDCODE    10'h006
`define JBSP_OP_USERCODE  10'h007
`define JBSP_OP_BYPASS    10'h3ff
`define JBSP_OP_CFG_PROG  10'h002
`define JBSP_OP_CFG_START 10'h003
// identification: values below are arbitrary
`define JBSP_ID_VERSION   4'ha
`define JBSP_ID_PART      16'h5c3e
`define JBSP_ID_MAKER     11'h2b1
// user signature: fixed 25 bits arbitrary, low 7 bits from configuration
`define JBSP_UC_FIXED     25'h0a5c3e1
`define JBSP_UC_USER_LEN  7
// boundary scan lengths per density
`define JBSP_BSR_SMALL    690
`define JBSP_BSR_MID      1308
`define JBSP_BSR_LARGE    1446
// tap states
`define JBSP_ST_W         4
`define JBSP_TLR          4'h0
`define JBSP_RTI          4'h1
`define JBSP_SDS          4'h2
`define JBSP_CDR          4'h3
`define JBSP_SDR          4'h4
`define JBSP_E1D          4'h5
`define JBSP_PDR          4'h6
`define JBSP_E2D          4'h7
`define JBSP_UDR          4'h8
`define JBSP_SIS          4'h9
`define JBSP_CIR          4'ha
`define JBSP_SIR          4'hb
`define JBSP_E1I          4'hc
`define JBSP_PIR          4'hd
`define JBSP_E2I          4'he
`define JBSP_UIR          4'hf
// configuration stream
`define JBSP_CFG_W        8
`define JBSP_CFG_DEPTH    16
`define JBSP_CFG_AW       4
`endif

// [jbsp_fifo.v]
`timescale 1ns/1ps
`default_nettype none
module jbsp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_mclk,    // clock
  input  wire             i_sys_rst, // sync reset
  input  wire [WIDTH-1:0] i_data,    // write data
  input  wire             i_valid,   // write valid
  output wire             o_ready,   // not full
  output wire [WIDTH-1:0] o_data,    // read data
  output wire             o_valid,   // not empty
  input  wire             i_ready    // read accept
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire            empty = (wr_ptr == rd_ptr);
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data  = mem[rd_ptr[AW-1:0]];
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (i_valid && !full) begin
        mem[wr_ptr[AW-1:0]] <= i_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (i_ready && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [jbsp_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module jbsp_monitor #(
  parameter BSR_LEN = 690
) (
  input wire logic               i_mclk,
  input wire logic               i_sys_rst,
  input wire logic               i_trst_n,
  input wire logic               i_cfg_ready,
  input wire logic               o_tdo_oe_n,
  input wire logic [BSR_LEN-1:0] o_pins,
  input wire logic               o_pin_test,
  input wire logic [7:0]         o_cfg_data,
  input wire logic               o_cfg_valid,
  input wire logic               o_cfg_start,
  input wire logic               o_cfg_ovf
);
  default clocking @(posedge i_mclk); endclocking
  sequence s_trst_held; !i_trst_n [*4]; endsequence
  sequence s_quiet; o_tdo_oe_n && !o_pin_test; endsequence
  property p_rst_out;
    i_sys_rst |=> s_quiet and !o_cfg_valid && o_pins == '0;
  endproperty
  property p_trst; disable iff (i_sys_rst) s_trst_held |=> s_quiet; endproperty
  property p_start; disable iff (i_sys_rst) o_cfg_start |=> !o_cfg_start; endproperty
  property p_ovf; disable iff (i_sys_rst) o_cfg_ovf |=> !o_cfg_ovf; endproperty
  property p_hold;
    disable iff (i_sys_rst) o_cfg_valid && !i_cfg_ready |=> o_cfg_valid && $stable(o_cfg_data);
  endproperty
  property p_pins_upd;
    disable iff (i_sys_rst) $changed(o_pins) |-> o_tdo_oe_n && $past(o_tdo_oe_n);
  endproperty
  property p_test_rise; disable iff (i_sys_rst) $rose(o_pin_test) |-> o_tdo_oe_n; endproperty
  property p_start_oe; disable iff (i_sys_rst) o_cfg_start |-> s_quiet; endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not idle after reset");
  a_trst: assert property (p_trst)
    else $error("test reset did not idle the port");
  a_start: assert property (p_start)
    else $error("start pulse too long");
  a_ovf: assert property (p_ovf)
    else $error("overflow pulse too long");
  a_hold: assert property (p_hold)
    else $error("stalled byte changed or dropped");
  a_pins_upd: assert property (p_pins_upd)
    else $error("pin pattern changed while shifting");
  a_test_rise: assert property (p_test_rise)
    else $error("pin test began while shifting");
  a_start_oe: assert property (p_start_oe)
    else $error("start pulse while shifting or testing");
endmodule
bind jbsp_tap jbsp_monitor #(.BSR_LEN(BSR_LEN)) jbsp_monitor_i (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_trst_n(i_trst_n), .i_cfg_ready(i_cfg_ready),
  .o_tdo_oe_n(o_tdo_oe_n), .o_pins(o_pins), .o_pin_test(o_pin_test),
  .o_cfg_data(o_cfg_data), .o_cfg_valid(o_cfg_valid), .o_cfg_start(o_cfg_start),
  .o_cfg_ovf(o_cfg_ovf));
`default_nettype wire

// [jbsp_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module jbsp_ctrl (
  input  wire logic i_mclk, // system clock
  input  wire logic i_tdo,  // device data out
  output logic      o_tck,  // test clock
  output logic      o_tms,  // mode select
  output logic      o_tdi   // data in, pulled up when idle
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // 160 ns tck; tdo taken mid high phase, after the device moved it on the fall
  task automatic bit_io(input logic tms, input logic tdi, output logic tdo);
    @(posedge i_mclk);
    o_tck <= 1'b0;
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (4) @(posedge i_mclk);
    o_tck <= 1'b1;
    repeat (2) @(posedge i_mclk);
    tdo = i_tdo;
    repeat (1) @(posedge i_mclk);
    o_tdi <= 1'b1;
  endtask
  // from run-test-idle, one ir or dr scan, lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [1535:0] din,
                      output logic [1535:0] dout);
    logic t;
    dout = '0;
    bit_io(1'b1, 1'b1, t);
    if (ir) bit_io(1'b1, 1'b1, t);
    bit_io(1'b0, 1'b1, t);
    bit_io(1'b0, 1'b1, t);
    for (int k = 0; k < n; k++) begin
      bit_io(k == n - 1, din[k], t);
      dout[k] = t;
    end
    bit_io(1'b1, 1'b1, t);
    bit_io(1'b0, 1'b1, t);
    // update-state results land on the last edge; let them settle before the caller looks
    repeat (2) @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

// [tb_jtag_boundary_scan_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "jbsp_defs.vh"
`define CHK(nm, e, g) check(nm, e, g)
module tb_jtag_boundary_scan_port;
  localparam int BL = `JBSP_BSR_SMALL;
  logic mclk = 1'b0, rst = 1'b1, trst_n = 1'b1, rdy = 1'b0, tck, tms, tdi, tdo, oe_n;
  logic test, vld, start, ovf;
  logic tdo_line;
  // a released tdo floats to its pull-up
  assign tdo_line = oe_n ? 1'b1 : tdo;
  logic [6:0] sig = 7'h00;
  logic [7:0] data, first;
  logic [BL-1:0] pins = '0, pins_o;
  logic [1535:0] v, d;
  int checked = 0, miscompares = 0, ovfs = 0, drained = 0, starts = 0;
  always #10 mclk = ~mclk;
  jbsp_ctrl ctrl_i (.i_mclk(mclk), .i_tdo(tdo_line), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  jbsp_tap jbsp_tap_i (.i_mclk(mclk), .i_sys_rst(rst), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe_n(oe_n), .i_pins(pins),
    .o_pins(pins_o), .o_pin_test(test), .i_user_sig(sig), .i_cfg_busy(1'b0),
    .o_cfg_data(data), .o_cfg_valid(vld), .i_cfg_ready(rdy), .o_cfg_start(start),
    .o_cfg_ovf(ovf));
  always @(posedge mclk) begin
    ovfs <= ovfs + int'(ovf);
    starts <= starts + int'(start);
    if (vld && rdy) begin
      if (drained == 0) first <= data;
      drained <= drained + 1;
    end
  end
  task automatic check(input string nm, input logic [1535:0] e, input logic [1535:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic ld(input logic [9:0] op);
    ctrl_i.scan(1'b1, 10, {1526'h0, op}, d);
    `CHK("ir capture", `JBSP_IR_CAPTURE, d[9:0]);
  endtask
  task automatic t_id_user();
    logic t;
    ctrl_i.bit_io(1'b0, 1'b1, t);
    ctrl_i.scan(1'b0, 32, '1, d);
    `CHK("idcode", {`JBSP_ID_VERSION, `JBSP_ID_PART, `JBSP_ID_MAKER, 1'b1}, d[31:0]);
    sig <= 7'h5a;
    ld(`JBSP_OP_USERCODE);
    ctrl_i.scan(1'b0, 32, '0, d);
    `CHK("usercode", {`JBSP_UC_FIXED, 7'h5a}, d[31:0]);
  endtask
  task automatic t_bypass(input logic [9:0] op);
    ld(op);
    ctrl_i.scan(1'b0, 16, 1536'hb4c3, d);
    `CHK("bypass", 16'h6986, d[15:0]);
  endtask
  task automatic t_pins();
    pins <= {69{10'h2d3}};
    ld(`JBSP_OP_SAMPLE);
    ctrl_i.scan(1'b0, BL, {{846{1'b0}}, {69{10'h1c6}}}, d);
    `CHK("sample capture", {69{10'h2d3}}, d[BL-1:0]);
    `CHK("preload", {69{10'h1c6}}, pins_o);
    `CHK("no pin test", 1'b0, test);
    pins <= {69{10'h0b5}};
    ld(`JBSP_OP_EXTEST);
    `CHK("pin test", 1'b1, test);
    ctrl_i.scan(1'b0, BL + 8, {{838{1'b0}}, {69{10'h339}}, 8'h96}, d);
    `CHK("extest capture", {69{10'h0b5}}, d[BL-1:0]);
    `CHK("chain length", 8'h96, d[BL+7:BL]);
    `CHK("extest drive", {69{10'h339}}, pins_o);
  endtask
  task automatic t_trst();
    logic t;
    ld(`JBSP_OP_BYPASS);
    trst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    trst_n <= 1'b1;
    ctrl_i.bit_io(1'b0, 1'b1, t);
    ctrl_i.scan(1'b0, 32, '1, d);
    `CHK("idcode after trst", {`JBSP_ID_VERSION, `JBSP_ID_PART, `JBSP_ID_MAKER, 1'b1}, d[31:0]);
  endtask
  task automatic t_cfg();
    v = '0;
    // sixteen buffered bytes plus the output stage hold seventeen; the eighteenth is lost
    for (int k = 0; k < 18; k++) v[8*k +: 8] = 8'(k + 1);
    ld(`JBSP_OP_CFG_PROG);
    ctrl_i.scan(1'b0, 144, v, d);
    `CHK("overflow", 1, ovfs);
    rdy <= 1'b1;
    for (int w = 0; w < 200 && drained < 17; w++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    `CHK("drained", 17, drained);
    `CHK("first byte", 8'h01, first);
    ld(`JBSP_OP_CFG_START);
    ctrl_i.scan(1'b0, 8, '0, d);
    `CHK("start", 1, starts);
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_id_user();
    t_bypass(`JBSP_OP_BYPASS);
    t_bypass(10'h155);
    t_pins();
    t_trst();
    t_cfg();
    print_verdict();
  end
endmodule
`default_nettype wire
